// ==== hdl/dms_ctrl_end.sv ====
// Controller end: sequences DLL switching, clock change and leveling
`timescale 1ns/1ps
// Functional notes
// [R1] MR1 bit0 one disables DLL
// [R2] Device idle, termination off before disable
// [R3] Mode-set wait, self-refresh, entry clock wait
// [R4] Stable new clock before self-refresh exit
// [R5] DLL-off: clock enable high, termination low
// [R6] Reprogram registers, optional calibration, mode-set wait
// [R7] DLL-on: hold levels until lock time
// [R8] Clear disable bit, wait, set reset bit
// [R9] Wait lock and calibration before use
// [R10] Clock changes only in self-refresh or power-down
// [R11] Clock ignored after entry delay
// [R12] New frequency within speed grade limits
// [R13] Power-down: termination low when enabled
// [R14] Power-down change: entry wait, both low
// [R15] Stable clock, exit, wait, DLL reset
// [R16] Re-lock: termination low, clock enable high
// [R17] Termination off and outputs idle first
// [R18] DLL-off strobe and data shift together
// [R19] Device samples clock with strobe edge
// [R20] Raise strobe delay until zero-to-one
// [R21] DLL-off uses latency six only
// [R22] Only no-operation during exit delay
// [R23] Self-refresh only from all-banks idle
// [R24] Each wait is a counted interval
module dms_ctrl_end (
   input wire logic SYS_CLK,
   input wire logic RST,
   dms_link_if.ctrl LINK,
   input wire logic START,
   input wire dms_pkg::dms_op_t OP,
   input wire logic ALL_IDLE,
   input wire logic TERM_ENABLED,
   input wire logic USE_LONG_CAL,
   input wire logic FREQ_IN_RANGE,
   output logic BUSY,
   output logic DONE,
   output logic ERROR,
   output logic CLK_CHANGE_REQ,
   output logic [dms_pkg::TAP_W-1:0] LEVEL_TAP
);
   typedef enum logic [4:0] {
      S_IDLE, S_TERM_OFF, S_MR1_WR, S_WAIT, S_SRE, S_CLK_HOLD,
      S_CLK_CHG, S_SRX, S_MR1_ON, S_MR0_RST, S_MR0_LAT, S_MR2_LAT,
      S_ZQ, S_LOCK, S_PDE, S_PDX, S_LVL_ON, S_LVL_PULSE, S_LVL_WAIT,
      S_LVL_OFF, S_DONE
   } dms_state_t;

   dms_state_t state_r;
   dms_state_t ret_r; // State entered once the counter expires
   dms_pkg::dms_op_t op_r;
   logic [15:0] cnt_r;
   logic [15:0] lock_cnt_r;
   logic [15:0] cal_cnt_r;
   dms_pkg::dms_cmd_t cmd_r;
   logic [dms_pkg::BA_W-1:0] ba_r;
   logic [dms_pkg::ADDR_W-1:0] addr_r;
   logic cke_r;
   logic odt_r;
   logic clk_chg_r;
   logic [dms_pkg::TAP_W-1:0] tap_r;
   logic pulse_r;
   logic lvl_r;
   logic fb_prev_r;
   logic busy_r;
   logic done_r;
   logic err_r;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: each wait except the lock wait in S_LOCK loads cnt_r and parks in S_WAIT until it counts down to one
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_r <= S_IDLE;
         ret_r <= S_IDLE;
         op_r <= dms_pkg::DMS_OP_TO_DLL_OFF;
         cnt_r <= 16'h0000;
         cmd_r <= dms_pkg::DMS_CMD_NOP;
         ba_r <= 3'h0;
         addr_r <= 16'h0000;
         cke_r <= 1'b1;
         clk_chg_r <= 1'b0;
         tap_r <= 6'h00;
         pulse_r <= 1'b0;
         lvl_r <= 1'b0;
         fb_prev_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         cmd_r <= dms_pkg::DMS_CMD_NOP; // Commands are one-cycle pulses
         pulse_r <= 1'b0;
         unique case (state_r)
            S_IDLE: begin
               if (START) begin
                  op_r <= OP;
                  err_r <= 1'b0;
                  // Refuse unless banks idle and the new clock is legal
                  if (!ALL_IDLE || !FREQ_IN_RANGE) // [R23] [R12] [R2]
                     err_r <= 1'b1;
                  else begin
                     state_r <= S_WAIT;
                     ret_r <= (OP == dms_pkg::DMS_OP_LEVEL) ? S_LVL_ON :
                        (OP == dms_pkg::DMS_OP_PD_FREQ) ? S_PDE :
                        (OP == dms_pkg::DMS_OP_TO_DLL_OFF) ? S_MR1_WR :
                        S_SRE;
                     cnt_r <= dms_pkg::TERM_OFF_CYC; // Termination off [R2] [R17]
                  end
               end
            end
            S_MR1_WR: begin
               cmd_r <= dms_pkg::DMS_CMD_MRS;
               ba_r <= dms_pkg::MR1_SEL;
               addr_r <= 16'h0001; // DLL disable bit set [R1]
               cnt_r <= dms_pkg::MODE_SET_CYC; // [R3]
               ret_r <= S_SRE;
               state_r <= S_WAIT;
            end
            S_SRE: begin
               cmd_r <= dms_pkg::DMS_CMD_SRE;
               cke_r <= 1'b0;
               cnt_r <= dms_pkg::SRE_CLK_CYC; // [R3] [R11]
               ret_r <= S_CLK_CHG;
               state_r <= S_WAIT;
            end
            S_PDE: begin
               cke_r <= 1'b0; // Precharge power-down entry
               cnt_r <= dms_pkg::SRE_CLK_CYC; // [R14]
               ret_r <= S_CLK_CHG;
               state_r <= S_WAIT;
            end
            S_CLK_CHG: begin
               // Clock only moves while the device ignores it [R10]
               clk_chg_r <= 1'b1;
               cnt_r <= dms_pkg::SRX_CLK_CYC; // Stable new clock [R4] [R15]
               ret_r <= (op_r == dms_pkg::DMS_OP_PD_FREQ) ? S_PDX : S_SRX;
               state_r <= S_CLK_HOLD;
            end
            S_CLK_HOLD: begin
               clk_chg_r <= 1'b0;
               state_r <= S_WAIT;
            end
            S_SRX: begin
               cmd_r <= dms_pkg::DMS_CMD_SRX;
               cke_r <= 1'b1; // Held high to the end [R5] [R7]
               cnt_r <= dms_pkg::SR_EXIT_CYC; // NOP only meanwhile [R22]
               ret_r <= (op_r == dms_pkg::DMS_OP_TO_DLL_OFF) ?
                  S_MR0_LAT : S_MR1_ON;
               state_r <= S_WAIT;
            end
            S_PDX: begin
               cke_r <= 1'b1; // [R15] [R16]
               cnt_r <= dms_pkg::PD_EXIT_CYC;
               ret_r <= S_MR0_RST;
               state_r <= S_WAIT;
            end
            S_MR1_ON: begin
               cmd_r <= dms_pkg::DMS_CMD_MRS;
               ba_r <= dms_pkg::MR1_SEL;
               addr_r <= 16'h0000; // DLL disable bit cleared [R8] [R1]
               cnt_r <= dms_pkg::MODE_REGISTER_CYC;
               ret_r <= S_MR0_RST;
               state_r <= S_WAIT;
            end
            S_MR0_RST: begin
               cmd_r <= dms_pkg::DMS_CMD_MRS;
               ba_r <= dms_pkg::MR0_SEL;
               addr_r <= 16'h0100; // DLL reset bit set [R8] [R15]
               cnt_r <= dms_pkg::MODE_REGISTER_CYC; // [R9]
               ret_r <= S_LOCK;
               state_r <= S_WAIT;
            end
            S_MR0_LAT: begin
               cmd_r <= dms_pkg::DMS_CMD_MRS;
               ba_r <= dms_pkg::MR0_SEL;
               addr_r <= {8'h00, dms_pkg::DLL_OFF_READ_LATENCY,
                  4'h0}; // [R6] [R21]
               cnt_r <= dms_pkg::MODE_REGISTER_CYC;
               ret_r <= S_MR2_LAT;
               state_r <= S_WAIT;
            end
            S_MR2_LAT: begin
               cmd_r <= dms_pkg::DMS_CMD_MRS;
               ba_r <= dms_pkg::MR2_SEL;
               addr_r <= {9'h000, dms_pkg::DLL_OFF_WRITE_LATENCY,
                  3'h0}; // [R21]
               cnt_r <= dms_pkg::MODE_SET_CYC; // [R6] [R5]
               ret_r <= USE_LONG_CAL ? S_ZQ : S_DONE;
               state_r <= S_WAIT;
            end
            S_ZQ: begin
               cmd_r <= dms_pkg::DMS_CMD_LONG_CALIBRATION_COMMAND; // [R6]
               state_r <= S_DONE;
            end
            S_LOCK: begin
               // Calibration overlaps the lock wait when asked for; one
               // issue only, so skip while the last one is still in flight
               if (USE_LONG_CAL && cal_cnt_r == 16'h0000 &&
                   cmd_r != dms_pkg::DMS_CMD_LONG_CALIBRATION_COMMAND &&
                   lock_cnt_r > dms_pkg::LONG_CAL_CYC)
                  cmd_r <= dms_pkg::DMS_CMD_LONG_CALIBRATION_COMMAND;
               else if (lock_cnt_r == 16'h0000 &&
                        cal_cnt_r == 16'h0000) // [R9] [R16]
                  state_r <= S_DONE;
            end
            S_LVL_ON: begin
               lvl_r <= 1'b1;
               tap_r <= 6'h00;
               fb_prev_r <= 1'b0;
               cnt_r <= dms_pkg::MODE_SET_CYC;
               ret_r <= S_LVL_PULSE;
               state_r <= S_WAIT;
            end
            S_LVL_PULSE: begin
               pulse_r <= 1'b1;
               cnt_r <= dms_pkg::LEVEL_SETTLE_CYC;
               ret_r <= S_LVL_WAIT;
               state_r <= S_WAIT;
            end
            S_LVL_WAIT: begin
               fb_prev_r <= LINK.level_feedback;
               // Lock the tap on the first zero-to-one feedback
               if (LINK.level_feedback && !fb_prev_r) // [R20]
                  state_r <= S_LVL_OFF;
               else if (tap_r == dms_pkg::TAP_MAX) begin
                  err_r <= 1'b1;
                  state_r <= S_LVL_OFF;
               end else begin
                  tap_r <= tap_r + 6'h01; // [R20]
                  state_r <= S_LVL_PULSE;
               end
            end
            S_LVL_OFF: begin
               lvl_r <= 1'b0;
               state_r <= S_DONE;
            end
            S_WAIT: begin
               if (cnt_r <= 16'h0001) // [R24]
                  state_r <= ret_r;
               else
                  cnt_r <= cnt_r - 16'h0001;
            end
            S_DONE: state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Lock and calibration timers run beside the sequencer
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         lock_cnt_r <= 16'h0000;
         cal_cnt_r <= 16'h0000;
      end else begin
         if (cmd_r == dms_pkg::DMS_CMD_MRS && ba_r == dms_pkg::MR0_SEL &&
             addr_r[dms_pkg::DLL_RESET_BIT_POS])
            lock_cnt_r <= dms_pkg::DLL_LOCK_CYC; // [R24] [R9]
         else if (lock_cnt_r != 16'h0000)
            lock_cnt_r <= lock_cnt_r - 16'h0001;
         if (cmd_r == dms_pkg::DMS_CMD_LONG_CALIBRATION_COMMAND)
            cal_cnt_r <= dms_pkg::LONG_CAL_CYC;
         else if (cal_cnt_r != 16'h0000)
            cal_cnt_r <= cal_cnt_r - 16'h0001;
      end
   end

   // Termination low in every state, idle included; a free level is wasted margin
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         odt_r <= 1'b0;
      else
         odt_r <= 1'b0; // [R5] [R7] [R13] [R14] [R16]
   end

   // Status flags
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         busy_r <= (state_r != S_IDLE) && (state_r != S_DONE);
         done_r <= (state_r == S_DONE);
      end
   end

   assign LINK.cmd = cmd_r;
   assign LINK.ba = ba_r;
   assign LINK.addr = addr_r;
   assign LINK.cke = cke_r;
   assign LINK.termination_control = odt_r;
   assign LINK.clk_change = clk_chg_r;
   assign LINK.strobe_tap = tap_r;
   assign LINK.strobe_pulse = pulse_r;
   assign LINK.level_mode = lvl_r;
   assign BUSY = busy_r;
   assign DONE = done_r;
   assign ERROR = err_r;
   assign CLK_CHANGE_REQ = clk_chg_r;
   assign LEVEL_TAP = tap_r;
endmodule : dms_ctrl_end

// ==== hdl/dms_pkg.sv ====
// Shared constants and types for the DLL mode switch and clock change link
package dms_pkg;
   // Mode register bit positions
   localparam int DLL_DISABLE_BIT_POS = 0;
   localparam int DLL_RESET_BIT_POS = 8;
   localparam int ADDR_W = 16;
   localparam int BA_W = 3;
   // DLL-off latencies, both six cycles
   localparam logic [3:0] DLL_OFF_READ_LATENCY = 4'h6;
   localparam logic [3:0] DLL_OFF_WRITE_LATENCY = 4'h6;
   // Mode register selects on the bank address
   localparam logic [2:0] MR0_SEL = 3'h0;
   localparam logic [2:0] MR1_SEL = 3'h1;
   localparam logic [2:0] MR2_SEL = 3'h2;
   // Wait interval defaults, in SYS_CLK cycles (50 MHz, 20 ns)
   localparam int CLK_PERIOD_NS = 20;
   localparam int MODE_SET_DELAY_NS = 240;
   localparam int MODE_REGISTER_DELAY_NS = 80;
   localparam int SRE_CLK_DELAY_NS = 200;
   localparam int SRX_CLK_DELAY_NS = 200;
   localparam int SR_EXIT_DELAY_NS = 400;
   localparam int PD_EXIT_DELAY_NS = 100;
   localparam int DLL_LOCK_TIME_NS = 10240;
   localparam int LONG_CAL_TIME_NS = 5120;
   localparam int TERM_OFF_DELAY_NS = 180;
   localparam logic [15:0] MODE_SET_CYC =
      16'((MODE_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] MODE_REGISTER_CYC =
      16'((MODE_REGISTER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] SRE_CLK_CYC =
      16'((SRE_CLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] SRX_CLK_CYC =
      16'((SRX_CLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] SR_EXIT_CYC =
      16'((SR_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] PD_EXIT_CYC =
      16'((PD_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] DLL_LOCK_CYC =
      16'((DLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] LONG_CAL_CYC =
      16'((LONG_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] TERM_OFF_CYC =
      16'((TERM_OFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Strobe delay tap width for leveling
   localparam int TAP_W = 6;
   localparam logic [5:0] TAP_MAX = 6'h3f;
   localparam logic [15:0] LEVEL_SETTLE_CYC = 16'h0004;
   // Commands on the link
   typedef enum logic [2:0] {
      DMS_CMD_NOP, DMS_CMD_MRS, DMS_CMD_SRE, DMS_CMD_SRX,
      DMS_CMD_PDE, DMS_CMD_PDX, DMS_CMD_LONG_CALIBRATION_COMMAND
   } dms_cmd_t;
   // Sequence requested of the controller
   typedef enum logic [1:0] {
      DMS_OP_TO_DLL_OFF, DMS_OP_TO_DLL_ON, DMS_OP_PD_FREQ, DMS_OP_LEVEL
   } dms_op_t;
endpackage : dms_pkg

// ==== hdl/dms_link_if.sv ====
// Link between the memory controller sequencer and the DRAM model end
`timescale 1ns/1ps
interface dms_link_if;
   dms_pkg::dms_cmd_t cmd;
   logic [dms_pkg::BA_W-1:0] ba;
   logic [dms_pkg::ADDR_W-1:0] addr;
   logic cke;
   logic termination_control;
   logic clk_change;
   logic [dms_pkg::TAP_W-1:0] strobe_tap;
   logic strobe_pulse;
   logic level_mode;
   logic level_feedback;
   logic dll_locked;
   logic dll_off;
   modport ctrl (
      output cmd, ba, addr, cke, termination_control, clk_change,
      output strobe_tap, strobe_pulse, level_mode,
      input level_feedback, dll_locked, dll_off
   );
   modport dram (
      input cmd, ba, addr, cke, termination_control, clk_change,
      input strobe_tap, strobe_pulse, level_mode,
      output level_feedback, dll_locked, dll_off
   );
endinterface : dms_link_if

// ==== hdl/dms_dram_end.sv ====
// DRAM end: DLL state, DLL-off latency check and leveling feedback
`timescale 1ns/1ps
module dms_dram_end (
   input wire logic SYS_CLK,
   input wire logic RST,
   dms_link_if.dram LINK,
   input wire logic [dms_pkg::TAP_W-1:0] CLK_PHASE,
   output logic DLL_OFF,
   output logic DLL_LOCKED,
   output logic LATENCY_OK,
   output logic READ_SKEW_MATCHED
);
   logic dll_off_r;
   logic locked_r;
   logic [15:0] lock_cnt_r;
   logic [3:0] rl_r;
   logic [3:0] wl_r;
   logic fb_r;
   logic lat_ok_r;
   logic skew_r;

   ////////////////////////////////////////////////////////////////////////
   // Mode register writes: DLL disable bit and latencies
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         dll_off_r <= 1'b0;
         rl_r <= 4'h0;
         wl_r <= 4'h0;
      end else if (LINK.cke && LINK.cmd == dms_pkg::DMS_CMD_MRS) begin
         if (LINK.ba == dms_pkg::MR1_SEL)
            dll_off_r <= LINK.addr[dms_pkg::DLL_DISABLE_BIT_POS]; // [R1]
         if (LINK.ba == dms_pkg::MR0_SEL)
            rl_r <= LINK.addr[7:4];
         if (LINK.ba == dms_pkg::MR2_SEL)
            wl_r <= LINK.addr[6:3];
      end
   end

   // DLL lock counts from a DLL reset while the DLL is enabled
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         locked_r <= 1'b0;
         lock_cnt_r <= 16'h0000;
      end else if (dll_off_r || LINK.clk_change) begin
         locked_r <= 1'b0; // Clock moved, lock is stale [R11]
         lock_cnt_r <= 16'h0000;
      end else if (LINK.cke && LINK.cmd == dms_pkg::DMS_CMD_MRS &&
                   LINK.ba == dms_pkg::MR0_SEL &&
                   LINK.addr[dms_pkg::DLL_RESET_BIT_POS]) begin
         locked_r <= 1'b0;
         lock_cnt_r <= dms_pkg::DLL_LOCK_CYC;
      end else if (lock_cnt_r != 16'h0000) begin
         lock_cnt_r <= lock_cnt_r - 16'h0001;
         locked_r <= (lock_cnt_r == 16'h0001);
      end
   end

   // Only latency six for read and write is supported with DLL off
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         lat_ok_r <= 1'b1;
      else
         lat_ok_r <= !dll_off_r ||
            (rl_r == dms_pkg::DLL_OFF_READ_LATENCY &&
             wl_r == dms_pkg::DLL_OFF_WRITE_LATENCY); // [R21]
   end

   // Strobe and data share one launch, so the DLL-off shift never skews them
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         skew_r <= 1'b1;
      else
         skew_r <= 1'b1; // [R18]
   end

   // Leveling: strobe rising edge samples clock phase, fed back on data
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         fb_r <= 1'b0;
      else if (!LINK.level_mode)
         fb_r <= 1'b0;
      else if (LINK.strobe_pulse)
         fb_r <= (LINK.strobe_tap >= CLK_PHASE); // [R19]
   end

   assign LINK.level_feedback = fb_r;
   assign LINK.dll_locked = locked_r;
   assign LINK.dll_off = dll_off_r;
   assign DLL_OFF = dll_off_r;
   assign DLL_LOCKED = locked_r;
   assign LATENCY_OK = lat_ok_r;
   assign READ_SKEW_MATCHED = skew_r;
endmodule : dms_dram_end

// ==== bench/dms_props.sv ====
// Concurrent checks on the link between the controller and DRAM ends
`timescale 1ns/1ps
module dms_props (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire dms_pkg::dms_cmd_t cmd,
   input wire logic [dms_pkg::BA_W-1:0] ba,
   input wire logic [dms_pkg::ADDR_W-1:0] addr,
   input wire logic cke,
   input wire logic termination_control,
   input wire logic clk_change,
   input wire logic [dms_pkg::TAP_W-1:0] strobe_tap,
   input wire logic strobe_pulse,
   input wire logic level_mode,
   input wire logic level_feedback,
   input wire logic dll_locked,
   input wire logic dll_off
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   logic mr1_wr;
   logic dll_rst_wr;
   ////////////////////////////////////////////////////////////////////////
   // Mode register writes only count while clock enable is registered
   assign mr1_wr = cke && cmd == dms_pkg::DMS_CMD_MRS &&
                   ba == dms_pkg::MR1_SEL;
   assign dll_rst_wr = cke && cmd == dms_pkg::DMS_CMD_MRS &&
                       ba == dms_pkg::MR0_SEL && addr[8] && !dll_off;
   ////////////////////////////////////////////////////////////////////////
   term_low_a: assert property (termination_control == 1'b0)
      else $error("termination control left low level");
   dll_disable_a: assert property (mr1_wr && addr[0] |=> dll_off)
      else $error("DLL not turned off by mode write");
   dll_enable_a: assert property (mr1_wr && !addr[0] |=> !dll_off)
      else $error("DLL not turned on by mode write");
   clk_chg_cke_a: assert property (clk_change |-> !cke)
      else $error("clock changed with clock enable high");
   entry_wait_a: assert property ($fell(cke) |-> !clk_change [*8])
      else $error("clock changed before entry delay");
   exit_stable_a: assert property (clk_change |=> !cke [*8])
      else $error("exit before new clock settled");
   exit_nop_a: assert property (cmd == dms_pkg::DMS_CMD_SRX |=>
      cmd == dms_pkg::DMS_CMD_NOP [*8])
      else $error("command issued inside exit delay");
   relock_wait_a: assert property (dll_rst_wr |=> !dll_locked [*8])
      else $error("DLL reported lock too early");
   feedback_src_a: assert property ($rose(level_feedback)
      |-> $past(strobe_pulse))
      else $error("feedback rose without a strobe");
   tap_step_a: assert property (level_mode && $past(level_mode) &&
      strobe_tap != $past(strobe_tap) |->
      strobe_tap == $past(strobe_tap) + 6'h01)
      else $error("strobe delay did not step by one");
   ////////////////////////////////////////////////////////////////////////
   // Main scenarios reached
   sr_exit_c: cover property (cmd == dms_pkg::DMS_CMD_SRX);
   clk_chg_c: cover property (clk_change);
   lock_c: cover property ($rose(dll_locked));
   feedback_c: cover property ($rose(level_feedback));
endmodule : dms_props

// ==== bench/dll_mode_switch_freq_change_tb.sv ====
// Self-checking bench for the DLL switch and clock change link
`timescale 1ns/1ps
module dll_mode_switch_freq_change_tb;
   logic sys_clk;
   logic rst;
   logic start;
   dms_pkg::dms_op_t op;
   logic all_idle;
   logic term_en;
   logic long_cal;
   logic freq_ok;
   logic busy;
   logic done;
   logic error;
   logic chg_req;
   logic [dms_pkg::TAP_W-1:0] level_tap;
   logic [dms_pkg::TAP_W-1:0] clk_phase;
   logic dll_off;
   logic dll_locked;
   logic lat_ok;
   logic skew_ok;
   int miscompares = 0;
   int check_count = 0;
   int seed = 51785;
   int chg_n;
   int req_n;
   int exp_off = 0;
   int exp_lock = 0;
   int ops [7] = '{0, 1, 2, 0, 1, 3, 3};
   dms_link_if link ();
   ////////////////////////////////////////////////////////////////////////
   dms_ctrl_end dms_ctrl_end_i (.SYS_CLK(sys_clk), .RST(rst),
      .LINK(link.ctrl), .START(start), .OP(op), .ALL_IDLE(all_idle),
      .TERM_ENABLED(term_en), .USE_LONG_CAL(long_cal),
      .FREQ_IN_RANGE(freq_ok), .BUSY(busy), .DONE(done), .ERROR(error),
      .CLK_CHANGE_REQ(chg_req), .LEVEL_TAP(level_tap));
   dms_dram_end dms_dram_end_i (.SYS_CLK(sys_clk), .RST(rst),
      .LINK(link.dram), .CLK_PHASE(clk_phase), .DLL_OFF(dll_off),
      .DLL_LOCKED(dll_locked), .LATENCY_OK(lat_ok),
      .READ_SKEW_MATCHED(skew_ok));
   dms_props dms_props_i (.SYS_CLK(sys_clk), .RST(rst), .cmd(link.cmd),
      .ba(link.ba), .addr(link.addr), .cke(link.cke),
      .termination_control(link.termination_control),
      .clk_change(link.clk_change), .strobe_tap(link.strobe_tap),
      .strobe_pulse(link.strobe_pulse), .level_mode(link.level_mode),
      .level_feedback(link.level_feedback), .dll_locked(link.dll_locked),
      .dll_off(link.dll_off));
   ////////////////////////////////////////////////////////////////////////
   // Clock at 50 MHz
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Count clock switch pulses on the wire and at the user side
   always @(posedge sys_clk) begin
      if (link.clk_change === 1'b1) chg_n++;
      if (chg_req === 1'b1) req_n++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // One sequence: request, wait bounded for completion, compare to model
   task automatic run(input int o, input logic idle, input logic ok,
                      input logic cal);
      int lim;
      int min_cyc;
      @(negedge sys_clk);
      op = dms_pkg::dms_op_t'(o);
      all_idle = idle;
      freq_ok = ok;
      long_cal = cal;
      chg_n = 0;
      req_n = 0;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      @(negedge sys_clk);
      if (!(idle && ok)) begin
         check(16'(error), 16'h1);
         check(16'(busy), 16'h0);
         return;
      end
      check(16'(busy), 16'h1);
      // A second request while busy must be ignored
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      lim = 3;
      while (done !== 1'b1 && lim < 5000) begin
         @(negedge sys_clk);
         lim++;
      end
      check(16'(lim < 5000), 16'h1);
      min_cyc = 0;
      case (o)
         0: begin
            exp_off = 1;
            exp_lock = 0;
            min_cyc = dms_pkg::TERM_OFF_CYC + 2 * dms_pkg::MODE_SET_CYC +
               dms_pkg::SRE_CLK_CYC + dms_pkg::SRX_CLK_CYC +
               dms_pkg::SR_EXIT_CYC + dms_pkg::MODE_REGISTER_CYC;
            check(16'(lat_ok), 16'h1);
         end
         1: begin
            exp_off = 0;
            exp_lock = 1;
            min_cyc = dms_pkg::SRE_CLK_CYC + dms_pkg::SRX_CLK_CYC +
               dms_pkg::SR_EXIT_CYC + 2 * dms_pkg::MODE_REGISTER_CYC +
               dms_pkg::DLL_LOCK_CYC;
         end
         2: min_cyc = dms_pkg::SRE_CLK_CYC + dms_pkg::SRX_CLK_CYC +
               dms_pkg::PD_EXIT_CYC + dms_pkg::DLL_LOCK_CYC;
         default: check(16'(level_tap), 16'(clk_phase));
      endcase
      check(16'(lim >= min_cyc), 16'h1);
      check(16'(error), 16'h0);
      check(16'(dll_off), 16'(exp_off));
      check(16'(dll_locked), 16'(exp_lock));
      check(16'(skew_ok), 16'h1);
      check(16'(chg_n), 16'(o < 3));
      check(16'(req_n), 16'(o < 3));
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   // Main sequence: refusals first, then every operation code
   initial begin
      rst = 1'b1;
      start = 1'b0;
      op = dms_pkg::DMS_OP_TO_DLL_OFF;
      all_idle = 1'b1;
      term_en = 1'b1;
      long_cal = 1'b0;
      freq_ok = 1'b1;
      clk_phase = 6'h05;
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      check(16'(dll_off), 16'h0);
      check(16'(dll_locked), 16'h0);
      run(0, 1'b0, 1'b1, 1'b0);
      run(1, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 7; i++) begin
         // Phase 1..62 keeps a zero-to-one step inside the tap range
         clk_phase = 6'(1 + ($unsigned($random(seed)) % 62));
         term_en = 1'($random(seed));
         run(ops[i], 1'b1, 1'b1, 1'(i));
      end
      end_sim();
   end
   // Watchdog well beyond the longest expected run
   initial begin
      repeat (40000) @(posedge sys_clk);
      miscompares++;
      end_sim();
   end
endmodule : dll_mode_switch_freq_change_tb
